// ===== hdl/adc_th_pkg.sv
// shared constants and types for the track/hold sequencer
package adc_th_pkg;
    localparam int          SAR_BITS            = 12;
    localparam logic [3:0]  FRAME_PAD           = 4'h0;  // four pad bits ahead of the result
    localparam logic [3:0]  BYTE_BITS           = 4'h8;
    localparam logic [3:0]  EXT_HOLD_POS        = 4'h1;  // second pulse of first result byte
    localparam logic [3:0]  SECOND_BYTE_POS     = 4'h8;
    localparam logic [2:0]  LAST_BIT_IN_BYTE    = 3'h7;
    // setup byte fields
    localparam int          SETUP_FLAG_BIT      = 7;
    localparam int          SEL_MSB             = 6;
    localparam int          SEL_LSB             = 4;
    localparam int          CLK_BIT             = 3;
    localparam int          BIP_BIT             = 2;
    localparam int          REF_ROLE_BIT        = 1;     // bit of the reference field
    // configuration byte fields
    localparam int          CS_MSB              = 4;
    localparam int          CS_LSB              = 1;
    localparam int          SGL_BIT             = 0;
    // reset values
    localparam logic [2:0]  SEL_RESET           = 3'h0;
    localparam logic        CLK_RESET           = 1'b0;
    localparam logic        BIP_RESET           = 1'b0;
    localparam logic [3:0]  CS_RESET            = 4'h0;
    localparam logic        SGL_RESET           = 1'b1;
    // module defaults
    localparam logic [6:0]  DEVICE_ADDR_DEFAULT = 7'h2A; // arbitrary value
    localparam int          CHANNELS_DEFAULT    = 12;
    localparam int          INT_CLK_DIV_DEFAULT = 25;

    typedef enum logic [2:0] {
        s_idle, s_addr, s_ack, s_write, s_convert, s_read, s_master_ack
    } bus_state_t;
endpackage : adc_th_pkg

// ===== hdl/sar_engine.sv
// successive-approximation register, one result bit per step
`timescale 1ns/100ps
module sar_engine
    import adc_th_pkg::*;
#(
    parameter int WIDTH = SAR_BITS
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             start,
    input  wire logic             step,
    input  wire logic             compare_high,
    output logic      [WIDTH-1:0] dac_code,
    output logic      [WIDTH-1:0] result,
    output logic                  busy,
    output logic                  done
);
    import adc_th_pkg::*;

    logic [WIDTH-1:0] mask;

    // one bit decided per step, msb first; the last step raises done
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mask     <= '0;
            result   <= '0;
            dac_code <= '0;
            busy     <= 1'b0;
            done     <= 1'b0;
        end else if (start) begin
            mask     <= {1'b1, {(WIDTH-1){1'b0}}};
            dac_code <= {1'b1, {(WIDTH-1){1'b0}}};
            result   <= '0;
            busy     <= 1'b1;
            done     <= 1'b0;
        end else if (busy && step) begin
            if (compare_high) begin
                result <= result | mask;
            end
            dac_code <= (compare_high ? dac_code : (dac_code & ~mask)) | (mask >> 1);
            mask     <= mask >> 1;
            busy     <= !mask[0];
            done     <= mask[0];
        end else begin
            done <= 1'b0;
        end
    end
endmodule : sar_engine

// ===== hdl/adc_track_hold_sequencer.sv
// track/hold sequencing, bus slave and channel steering for a 12-bit sar converter
//
// How it works
// - in internal clock mode tracking starts on the eighth rising bus clock of the address.
// - in internal clock mode the sample is held on the falling edge of the address ack pulse.
// - after hold in internal mode conversion runs on the own clock with bus clock held low.
// - in external mode tracking starts on the rising edge of a read bit after a matching address.
// - in external mode hold comes on the second rising edge of the first result byte.
// - in external mode the conversion steps on the twelve bus clocks after the hold point.
// - each conversion takes twelve conversion clocks, one result bit per clock.
// - the acquisition window spans those edges, 1.5 periods internal and 3 external.
// - with single-ended select at 1 the chosen channel is converted against ground.
// - with single-ended select at 0 the chosen pair drives both capacitor inputs.
// - the highest input doubles as reference pin, its role set by the reference field.
// - each result is 12 bits shifted out serially on the bus.
// - the multiplexer has 4 or 12 channels and the channel field addresses them.
// - a written byte with msb 1 is the setup byte, with msb 0 the configuration byte.
// - single-ended mode always uses unipolar coding.
`timescale 1ns/100ps
module adc_track_hold_sequencer
    import adc_th_pkg::*;
#(
    parameter logic [6:0] DEVICE_ADDR = DEVICE_ADDR_DEFAULT,
    parameter int         CHANNELS    = CHANNELS_DEFAULT,
    parameter int         INT_CLK_DIV = INT_CLK_DIV_DEFAULT
) (
    input  wire logic                clock,
    input  wire logic                rst_n,
    input  wire logic                scl_in,
    output logic                     scl_out,
    output logic                     scl_oe,
    input  wire logic                sda_in,
    output logic                     sda_out,
    output logic                     sda_oe,
    input  wire logic                comparator_high,
    output logic      [SAR_BITS-1:0] dac_code,
    output logic                     track_enable,
    output logic      [3:0]          mux_pos_sel,
    output logic      [3:0]          mux_neg_sel,
    output logic                     neg_to_ground,
    output logic                     bipolar_coding,
    output logic      [2:0]          reference_select,
    output logic                     input_or_reference_pin_ref,
    output logic                     ext_clock_mode,
    output logic                     converting,
    output logic      [SAR_BITS-1:0] result_data
);
    import adc_th_pkg::*;

    localparam int DIV_W = (INT_CLK_DIV > 1) ? $clog2(INT_CLK_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INT_CLK_DIV - 1);
    localparam logic [3:0] LAST_CH = 4'(CHANNELS - 1);

    bus_state_t    state;
    logic [1:0]    pin_in;
    logic [2:0]    pin_sync [2];
    logic [1:0]    pin_lvl;
    logic [1:0]    pin_prev;
    logic          scl_rise, scl_fall, bus_start, bus_stop;
    logic [7:0]    shift;
    logic [3:0]    bit_cnt;
    logic [3:0]    rd_pos;
    logic          addr_hit, rw_read, master_acked;
    logic [2:0]    sel_field;
    logic          bip_bit, single_diff_select;
    logic [3:0]    chan_select;
    logic [DIV_W-1:0] div_cnt;
    logic          div_tick;
    logic          sar_start, sar_step, sar_busy, sar_done;
    logic          addr_last_rise, ack_fall, byte_stored, ext_hold_rise;

    assign pin_in  = {sda_in, scl_in};
    assign scl_out = 1'b0; // open drain: only ever pulls low
    assign sda_out = 1'b0;

    // frame bit at a serial position, msb first: pad then result
    function automatic logic frame_bit(input logic [3:0] pos, input logic [SAR_BITS-1:0] r);
        logic [15:0] frame;
        frame = {FRAME_PAD, r};
        return frame[~pos];
    endfunction : frame_bit

    // clamp a channel number into the fitted multiplexer
    function automatic logic [3:0] clamp_ch(input logic [3:0] ch);
        return (ch > LAST_CH) ? LAST_CH : ch;
    endfunction : clamp_ch

    // three-stage synchronisers; a level counts when stages two and three agree
    generate
        for (genvar i = 0; i < 2; i++) begin : g_sync
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    pin_sync[i] <= 3'h7;
                    pin_lvl[i]  <= 1'b1;
                    pin_prev[i] <= 1'b1;
                end else begin
                    pin_sync[i] <= {pin_sync[i][1:0], pin_in[i]};
                    if (pin_sync[i][1] == pin_sync[i][2]) begin
                        pin_lvl[i] <= pin_sync[i][2];
                    end
                    pin_prev[i] <= pin_lvl[i];
                end
            end
        end
    endgenerate

    // bus events from the filtered levels
    assign scl_rise  = pin_lvl[0] && !pin_prev[0];
    assign scl_fall  = !pin_lvl[0] && pin_prev[0];
    assign bus_start = pin_lvl[0] && pin_prev[0] && pin_prev[1] && !pin_lvl[1];
    assign bus_stop  = pin_lvl[0] && pin_prev[0] && !pin_prev[1] && pin_lvl[1];

    // qualified moments that steer the track/hold
    assign addr_last_rise = (state == s_addr) && scl_rise && (bit_cnt == BYTE_BITS - 4'h1);
    assign ack_fall       = (state == s_ack) && scl_fall;
    assign byte_stored    = (state == s_write) && scl_fall && (bit_cnt == BYTE_BITS);
    assign ext_hold_rise  = (state == s_read) && scl_rise && ext_clock_mode
                            && (rd_pos == EXT_HOLD_POS);

    // bus slave: address, ack, write bytes, stretch, result shift-out
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state        <= s_idle;
            shift        <= 8'h00;
            bit_cnt      <= 4'h0;
            rd_pos       <= 4'h0;
            addr_hit     <= 1'b0;
            rw_read      <= 1'b0;
            master_acked <= 1'b0;
            sda_oe       <= 1'b0;
            scl_oe       <= 1'b0;
        end else if (bus_start) begin
            state   <= s_addr;
            bit_cnt <= 4'h0;
            sda_oe  <= 1'b0;
        end else if (bus_stop && state != s_convert) begin
            // a stop mid-conversion is ignored so the stretch always ends cleanly
            state  <= s_idle;
            sda_oe <= 1'b0;
        end else begin
            case (state)
                s_addr, s_write: begin
                    if (scl_rise) begin
                        shift   <= {shift[6:0], pin_lvl[1]};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    if (addr_last_rise) begin
                        addr_hit <= (shift[6:0] == DEVICE_ADDR);
                        rw_read  <= pin_lvl[1];
                    end
                    if (scl_fall && bit_cnt == BYTE_BITS) begin
                        if (state == s_write || addr_hit) begin
                            state  <= s_ack;
                            sda_oe <= 1'b1;
                        end else begin
                            state <= s_idle;
                        end
                    end
                end
                s_ack: begin
                    if (scl_fall) begin
                        sda_oe  <= 1'b0;
                        bit_cnt <= 4'h0;
                        if (!rw_read) begin
                            state <= s_write;
                        end else if (ext_clock_mode) begin
                            state  <= s_read;
                            rd_pos <= 4'h0;
                            sda_oe <= !frame_bit(4'h0, result_data);
                        end else begin
                            state  <= s_convert;
                            scl_oe <= 1'b1;
                        end
                    end
                end
                s_convert: begin
                    if (sar_done) begin
                        // result is final in this cycle, so release and drive bit 0
                        state  <= s_read;
                        scl_oe <= 1'b0;
                        rd_pos <= 4'h0;
                        sda_oe <= !frame_bit(4'h0, result_data);
                    end
                end
                s_read: begin
                    if (scl_fall) begin
                        if (rd_pos[2:0] == LAST_BIT_IN_BYTE) begin
                            state  <= s_master_ack;
                            sda_oe <= 1'b0;
                        end else begin
                            rd_pos <= rd_pos + 4'h1;
                            sda_oe <= !frame_bit(rd_pos + 4'h1, result_data);
                        end
                    end
                end
                s_master_ack: begin
                    if (scl_rise) begin
                        master_acked <= !pin_lvl[1];
                    end
                    if (scl_fall) begin
                        if (master_acked && !rd_pos[3]) begin
                            state  <= s_read;
                            rd_pos <= SECOND_BYTE_POS;
                            sda_oe <= !frame_bit(SECOND_BYTE_POS, result_data);
                        end else begin
                            state <= s_idle;
                        end
                    end
                end
                default: begin
                    state <= s_idle;
                end
            endcase
        end
    end

    // setup and configuration bytes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sel_field          <= SEL_RESET;
            ext_clock_mode     <= CLK_RESET;
            bip_bit            <= BIP_RESET;
            chan_select        <= CS_RESET;
            single_diff_select <= SGL_RESET;
        end else if (byte_stored) begin
            if (shift[SETUP_FLAG_BIT]) begin
                sel_field      <= shift[SEL_MSB:SEL_LSB];
                ext_clock_mode <= shift[CLK_BIT];
                bip_bit        <= shift[BIP_BIT];
            end else begin
                chan_select        <= shift[CS_MSB:CS_LSB];
                single_diff_select <= shift[SGL_BIT];
            end
        end
    end

    // track/hold switch; track spans 8th rise to ack fall, or read rise to 2nd data rise
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            track_enable <= 1'b0;
        end else if (addr_last_rise && shift[6:0] == DEVICE_ADDR
                     && (!ext_clock_mode || pin_lvl[1])) begin
            track_enable <= 1'b1;
        end else if ((ack_fall && rw_read && !ext_clock_mode) || ext_hold_rise) begin
            track_enable <= 1'b0;
        end
    end

    // internal conversion clock divider
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt  <= '0;
            div_tick <= 1'b0;
        end else begin
            div_tick <= (div_cnt == DIV_LAST);
            div_cnt  <= (div_cnt == DIV_LAST) ? '0 : div_cnt + DIV_W'(1);
        end
    end

    assign sar_start = (ack_fall && rw_read && !ext_clock_mode) || ext_hold_rise;
    // external mode steps on the bus clock, internal on the divider
    assign sar_step  = ext_clock_mode ? scl_rise : div_tick;
    assign converting = sar_busy;

    sar_engine #(
        .WIDTH (SAR_BITS)
    ) u_sar (
        .clock        (clock),
        .rst_n        (rst_n),
        .start        (sar_start),
        .step         (sar_step),
        .compare_high (comparator_high),
        .dac_code     (dac_code),
        .result       (result_data),
        .busy         (sar_busy),
        .done         (sar_done)
    );

    // channel steering, coding and reference pin role
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mux_pos_sel                <= 4'h0;
            mux_neg_sel                <= 4'h0;
            neg_to_ground              <= 1'b1;
            bipolar_coding             <= 1'b0;
            reference_select           <= SEL_RESET;
            input_or_reference_pin_ref <= 1'b0;
        end else begin
            mux_pos_sel      <= clamp_ch(chan_select);
            mux_neg_sel      <= single_diff_select ? 4'h0 : clamp_ch(chan_select ^ 4'h1);
            neg_to_ground    <= single_diff_select;
            bipolar_coding   <= bip_bit && !single_diff_select;
            reference_select <= sel_field;
            input_or_reference_pin_ref <= sel_field[REF_ROLE_BIT];
        end
    end
endmodule : adc_track_hold_sequencer

// ===== test/adc_th_chk.sv
// port assertions for the track/hold sequencer
`timescale 1ns/100ps
module adc_th_chk
    import adc_th_pkg::*;
#(
    parameter int CHANNELS = CHANNELS_DEFAULT
) (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       scl_oe,
    input wire logic       track_enable,
    input wire logic [3:0] mux_pos_sel,
    input wire logic [3:0] mux_neg_sel,
    input wire logic       neg_to_ground,
    input wire logic       bipolar_coding,
    input wire logic [2:0] reference_select,
    input wire logic       input_or_reference_pin_ref,
    input wire logic       ext_clock_mode,
    input wire logic       converting
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // the line stays low for the whole self-clocked conversion
    a_stretch_busy: assert property (converting && !ext_clock_mode |-> scl_oe)
        else $error("bus clock not held during conversion");
    a_stretch_cause: assert property ($rose(scl_oe) |-> converting)
        else $error("bus clock held without a conversion");
    a_release_done: assert property ($fell(scl_oe) |-> !converting)
        else $error("bus clock released before result ready");
    a_hold_convert: assert property (converting |-> !track_enable)
        else $error("sample not held while converting");
    a_ext_free: assert property (ext_clock_mode |-> !scl_oe)
        else $error("bus clock stretched in external mode");
    a_single_ground: assert property (neg_to_ground |-> mux_neg_sel == 4'h0 && !bipolar_coding)
        else $error("single-ended steering or coding wrong");
    a_diff_pair: assert property (!neg_to_ground |-> mux_neg_sel == (mux_pos_sel ^ 4'h1))
        else $error("differential pair steering wrong");
    a_chan_range: assert property (mux_pos_sel < CHANNELS)
        else $error("channel outside the multiplexer");
    a_ref_role: assert property (input_or_reference_pin_ref == reference_select[1])
        else $error("reference pin role wrong");
endmodule : adc_th_chk

bind adc_track_hold_sequencer adc_th_chk #(.CHANNELS(CHANNELS)) chk (
    .clock(clock), .rst_n(rst_n), .scl_oe(scl_oe), .track_enable(track_enable),
    .mux_pos_sel(mux_pos_sel), .mux_neg_sel(mux_neg_sel), .neg_to_ground(neg_to_ground),
    .bipolar_coding(bipolar_coding), .reference_select(reference_select),
    .input_or_reference_pin_ref(input_or_reference_pin_ref),
    .ext_clock_mode(ext_clock_mode), .converting(converting)
);

// ===== test/bus_master_model.sv
// two-wire bus master model on open-drain clock and data lines
`timescale 1ns/100ps
module bus_master_model (
    input  wire logic clock,
    input  wire logic scl_oe,
    input  wire logic sda_oe,
    output logic      scl_line,
    output logic      sda_line,
    output logic      stalled
);
    logic scl_pull = 1'b0;
    logic sda_pull = 1'b0;

    // released lines float up through the pull-ups
    assign scl_line = !(scl_pull || scl_oe);
    assign sda_line = !(sda_pull || sda_oe);
    initial stalled = 1'b0;

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock);
    endtask : wait_clk

    // one 17-clock bit slot; high phase waits out a stretched clock
    task automatic bit_slot(input logic b, output logic r);
        int n;
        n = 0;
        wait_clk(4);
        sda_pull <= !b;
        wait_clk(4);
        scl_pull <= 1'b0;
        while (!scl_line && n < 4000) begin
            @(posedge clock);
            n++;
        end
        if (n >= 4000) stalled <= 1'b1;
        wait_clk(4);
        r = sda_line;
        wait_clk(4);
        scl_pull <= 1'b1;
    endtask : bit_slot

    // data falls while the clock is high
    task automatic start_cond();
        sda_pull <= 1'b1;
        wait_clk(8);
        scl_pull <= 1'b1;
    endtask : start_cond

    task automatic stop_cond();
        wait_clk(4);
        sda_pull <= 1'b1;
        wait_clk(4);
        scl_pull <= 1'b0;
        wait_clk(8);
        sda_pull <= 1'b0;
        wait_clk(8);
    endtask : stop_cond

    // lsb of an address byte picks read (1) or write (0)
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_slot(b[i], r);
        bit_slot(1'b1, ack);
    endtask : send_byte
endmodule : bus_master_model

// ===== test/testbench.sv
// self-checking bench for the track/hold sequencer
`timescale 1ns/100ps
module testbench;
    import adc_th_pkg::*;
    localparam logic [6:0] ADDR = DEVICE_ADDR_DEFAULT;
    logic        clock;
    logic        rst_n = 1'b0;
    logic        comparator_high;
    logic [11:0] target = 12'h000;
    logic [11:0] dac_code;
    logic [11:0] result_data;
    logic [3:0]  mux_pos_sel, mux_neg_sel;
    logic [2:0]  reference_select;
    logic        scl_line, sda_line, scl_oe, sda_oe, stalled, track_enable, converting;
    logic        scl_out, sda_out;
    logic        neg_to_ground, bipolar_coding, ref_pin, ext_clock_mode;
    int          num_errors = 0;
    int          num_checks = 0;

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // comparator stands in for the analog input at level target; continuous like the
    // real one, so a step right after start already sees the fresh trial word
    assign comparator_high = (target >= dac_code);

    bus_master_model m (.clock(clock), .scl_oe(scl_oe), .sda_oe(sda_oe),
        .scl_line(scl_line), .sda_line(sda_line), .stalled(stalled));

    adc_track_hold_sequencer #(.INT_CLK_DIV(4)) dut (.clock(clock), .rst_n(rst_n),
        .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_line),
        .sda_out(sda_out),
        .sda_oe(sda_oe), .comparator_high(comparator_high), .dac_code(dac_code),
        .track_enable(track_enable), .mux_pos_sel(mux_pos_sel), .mux_neg_sel(mux_neg_sel),
        .neg_to_ground(neg_to_ground), .bipolar_coding(bipolar_coding),
        .reference_select(reference_select), .input_or_reference_pin_ref(ref_pin),
        .ext_clock_mode(ext_clock_mode), .converting(converting), .result_data(result_data));

    // small delay lets the edge's register updates land first
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        #1;
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results

    // write frame carrying two bytes, each acknowledged
    task automatic wr2(input logic [7:0] b0, input logic [7:0] b1);
        logic a;
        m.start_cond();
        m.send_byte({ADDR, 1'b0}, a);
        check(12'(a), 12'h0);
        m.send_byte(b0, a);
        check(12'(a), 12'h0);
        m.send_byte(b1, a);
        check(12'(a), 12'h0);
        m.stop_cond();
    endtask : wr2

    // read frame: pad nibble and 12 result bits, msb first
    task automatic rd(input logic [11:0] t, input logic ext);
        logic       a;
        logic [7:0] hi, lo;
        target <= t;
        m.start_cond();
        for (int i = 6; i >= 0; i--) m.bit_slot(ADDR[i], a);
        if (!ext) check(12'(track_enable), 12'h0);
        m.bit_slot(1'b1, a);
        check(12'(track_enable), 12'h1);
        m.bit_slot(1'b1, a);
        check(12'(a), 12'h0);
        if (!ext) begin
            m.wait_clk(6);
            check(12'(track_enable), 12'h0);
            check(12'({scl_oe, converting}), 12'h3);
        end
        for (int i = 7; i >= 0; i--) begin
            m.bit_slot(1'b1, hi[i]);
            if (ext && i == 7) check(12'(track_enable), 12'h1);
            if (ext && i == 6) check(12'({track_enable, converting}), 12'h1);
        end
        m.bit_slot(1'b0, a);
        for (int i = 7; i >= 0; i--) m.bit_slot(1'b1, lo[i]);
        m.bit_slot(1'b1, a);
        m.stop_cond();
        check({4'h0, hi}, {4'h0, t[11:8]});
        check({4'h0, lo}, {4'h0, t[7:0]});
        check(result_data, t);
        check(12'(scl_oe), 12'h0);
    endtask : rd

    task automatic t_internal_read();
        check(12'({ext_clock_mode, neg_to_ground}), 12'h1);
        check(12'({scl_out, sda_out}), 12'h0);
        rd(12'hA5C, 1'b0);
        rd(12'hFFF, 1'b0);
    endtask : t_internal_read

    // differential pair with bipolar coding, then an out-of-range single-ended channel
    // that must clamp to the top input of the fitted multiplexer
    task automatic t_config();
        wr2(8'hB4, 8'h08);
        m.wait_clk(4);
        check({9'h0, reference_select}, 12'h3);
        check(12'(ref_pin), 12'h1);
        check(12'({bipolar_coding, neg_to_ground}), 12'h2);
        check({4'h0, mux_pos_sel, mux_neg_sel}, 12'h045);
        wr2(8'h1F, 8'hB4);
        m.wait_clk(4);
        check(12'({bipolar_coding, neg_to_ground}), 12'h1);
        check({4'h0, mux_pos_sel, mux_neg_sel}, 12'h0B0);
    endtask : t_config

    task automatic t_external_read();
        wr2(8'h88, 8'h17);
        m.wait_clk(4);
        check(12'(ext_clock_mode), 12'h1);
        check(12'(ref_pin), 12'h0);
        rd(12'h3C7, 1'b1);
        rd(12'h001, 1'b1);
    endtask : t_external_read

    // foreign address gets no acknowledge
    task automatic t_bad_address();
        logic a;
        m.start_cond();
        m.send_byte({ADDR ^ 7'h01, 1'b1}, a);
        check(12'(a), 12'h1);
        m.stop_cond();
        check(12'(stalled), 12'h0);
    endtask : t_bad_address

    initial begin
        #100000;
        num_errors++;
        results();
    end

    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        m.wait_clk(6);
        t_internal_read();
        t_config();
        t_external_read();
        t_bad_address();
        results();
    end
endmodule : testbench
